/* File: fmx_pkg.sv */
// package: constants, register map and field layout of the fault mask exception unit
// Overview of operation
// - Status bits with polarity-invert mask bit one are inverted, others pass.
// - Writing one to a latch-clear bit clears that latched status bit.
// - Latch-select bits hold their processed status bit set; others follow source.
// - Fault status register is 24 bits, one processed condition per bit except reserved bits 10, 22, 23.
// - Bits 0,1 encoder errors; 2 drive fault; 3,5 user inputs 2,1; 4 encoder.
// - Bits 6,7 soft limits plus/minus; bits 8,9 hard limits plus/minus.
// - Bit 11 resolver error; bits 12-15 position, velocity, accel, current-limit traps.
// - Bits 16-18 software traps 1-3; 19,20 task run-time errors; 21 calibration.
// - Any status AND drive-disable mask bit switches off the amplifier stage.
// - Any status AND service-request mask bit raises a service request.
// - Any status AND auxiliary mask bit asserts the auxiliary output.
// - Any status AND freeze mask bit performs a fast feed hold.
// - Any status AND first-task mask bit triggers first-task exception, selected operation.
// - Any status AND second-task mask bit triggers second-task exception, selected operation.
// - Any status AND positive-direction mask bit blocks positive motion.
// - Any status AND negative-direction mask bit blocks negative motion.
// - Each initiated action sets its action-active bit, one meaning active.
// - Active bits: 0 disable, 1 unused, 2-6 srq/aux/freeze/task1/task2, 7-8 inhibits.
// - All masks use the fault status bit assignment, one bit per status bit.
// - Evaluation runs periodically, at least every 12.8 ms, configurable interval.
// - Service request from the mask carries status code 0x33.
package fmx_pkg;
	localparam int STW = 24;
	localparam int ACW = 9;
	localparam int AW  = 5;
	localparam int DW  = 32;

	localparam logic [AW-1:0] ADDR_INVERT   = 5'h00;
	localparam logic [AW-1:0] ADDR_LATCH_CL = 5'h01;
	localparam logic [AW-1:0] ADDR_LATCH_SL = 5'h02;
	localparam logic [AW-1:0] ADDR_STATUS   = 5'h03;
	localparam logic [AW-1:0] ADDR_ACT_MASK = 5'h04; // eight action masks at 0x04..0x0b
	localparam logic [AW-1:0] ADDR_ACTIVE   = 5'h0c;
	localparam logic [AW-1:0] ADDR_TASK_SEL = 5'h0d;
	localparam logic [AW-1:0] ADDR_INTERVAL = 5'h0e;
	localparam logic [AW-1:0] ADDR_SRQ_CODE = 5'h0f;

	localparam int ACT_DISABLE = 0;
	localparam int ACT_SRQ     = 2;
	localparam int ACT_AUX     = 3;
	localparam int ACT_FREEZE  = 4;
	localparam int ACT_TASK1   = 5;
	localparam int ACT_TASK2   = 6;
	localparam int ACT_POS     = 7;
	localparam int ACT_NEG     = 8;
	localparam int NMASK       = 8;

	// action index per mask slot 0..7
	localparam int MASK_ACT [NMASK] = '{0, 2, 3, 4, 5, 6, 7, 8};

	localparam logic [STW-1:0] STATUS_VALID = 24'h3ffbff;
	localparam logic [7:0]     SRQ_CODE_EXC = 8'h33;

	localparam int           CLK_HZ        = 25000000;
	localparam int           MAX_PERIOD_US = 12800;
	localparam int           TICK_US       = 100;
	localparam int           TICK_CYC      = CLK_HZ / 1000000 * TICK_US;
	localparam logic [7:0]   MAX_TICKS     = 8'(MAX_PERIOD_US / TICK_US);
	localparam logic [7:0]   INTERVAL_RST  = 8'h80;
	localparam logic [7:0]   TASK_SEL_RST  = 8'h00;
endpackage : fmx_pkg

/* File: fmx_unit.sv */
// fault mask exception unit: status processing, action masks and register port
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module fmx_unit
	import fmx_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic [STW-1:0]  fault_in,
	input  wire logic [AW-1:0]   addr,
	input  wire logic [DW-1:0]   wdata,
	input  wire logic            wr,
	input  wire logic            rd,
	output logic      [DW-1:0]   rdata,
	output logic                 amp_enable,
	output logic                 srq_out,
	output logic      [7:0]      srq_code,
	output logic                 aux_out,
	output logic                 feed_hold,
	output logic                 task1_exc,
	output logic      [3:0]      task1_op,
	output logic                 task2_exc,
	output logic      [3:0]      task2_op,
	output logic                 pos_inhibit,
	output logic                 neg_inhibit,
	output logic                 eval_tick
);

	logic [STW-1:0] polarity_invert_mask;
	logic [STW-1:0] latch_select_mask;
	logic [STW-1:0] act_mask [NMASK];
	logic [STW-1:0] fault_status;
	logic [ACW-1:0] action_active_status;
	logic [7:0]     exception_update_interval;
	logic [3:0]     first_task_exception_select;
	logic [3:0]     second_task_exception_select;
	logic [STW-1:0] clear_pend;
	logic [15:0]    cyc_cnt;
	logic [7:0]     tick_cnt;
	logic           base_tick;
	logic [STW-1:0] next_status;
	logic [ACW-1:0] next_active;
	logic [7:0]     interval_eff;

	function automatic logic any_hit(input logic [STW-1:0] st, input logic [STW-1:0] m);
		any_hit = |(st & m & STATUS_VALID);
	endfunction : any_hit

	// register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			polarity_invert_mask         <= '0;
			latch_select_mask            <= '0;
			exception_update_interval    <= INTERVAL_RST;
			first_task_exception_select  <= TASK_SEL_RST[3:0];
			second_task_exception_select <= TASK_SEL_RST[3:0];
			for (int i = 0; i < NMASK; i++) begin
				act_mask[i] <= '0;
			end
		end else if (wr) begin
			if (addr == ADDR_INVERT) begin
				polarity_invert_mask <= wdata[STW-1:0] & STATUS_VALID;
			end else if (addr == ADDR_LATCH_SL) begin
				latch_select_mask <= wdata[STW-1:0] & STATUS_VALID;
			end else if (addr >= ADDR_ACT_MASK && addr < ADDR_ACTIVE) begin
				act_mask[3'(addr - ADDR_ACT_MASK)] <= wdata[STW-1:0] & STATUS_VALID;
			end else if (addr == ADDR_TASK_SEL) begin
				first_task_exception_select  <= wdata[3:0];
				second_task_exception_select <= wdata[11:8];
			end else if (addr == ADDR_INTERVAL) begin
				exception_update_interval <= wdata[7:0];
			end
		end
	end

	// clears wait for the next evaluation; a set there wins over them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_pend <= '0;
		end else if (wr && addr == ADDR_LATCH_CL) begin
			clear_pend <= (eval_tick ? '0 : clear_pend) | wdata[STW-1:0];
		end else if (eval_tick) begin
			clear_pend <= '0;
		end
	end

	// evaluation period divider, clamped to the slowest allowed interval
	assign interval_eff = (exception_update_interval == 8'h00 ||
		exception_update_interval > MAX_TICKS) ? MAX_TICKS : exception_update_interval;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt   <= '0;
			base_tick <= 1'b0;
		end else if (cyc_cnt == 16'(TICK_CYCLES - 1)) begin
			cyc_cnt   <= '0;
			base_tick <= 1'b1;
		end else begin
			cyc_cnt   <= cyc_cnt + 16'h0001;
			base_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt  <= '0;
			eval_tick <= 1'b0;
		end else if (base_tick && tick_cnt >= interval_eff - 8'h01) begin
			tick_cnt  <= '0;
			eval_tick <= 1'b1;
		end else begin
			if (base_tick) begin
				tick_cnt <= tick_cnt + 8'h01;
			end
			eval_tick <= 1'b0;
		end
	end

	// invert, then latch selected bits; reserved bits forced low
	always_comb begin
		logic [STW-1:0] inv;
		inv = fault_in ^ polarity_invert_mask;
		next_status = (inv | (fault_status & latch_select_mask & ~clear_pend))
			& STATUS_VALID;
	end

	always_comb begin
		next_active = '0;
		for (int i = 0; i < NMASK; i++) begin
			next_active[MASK_ACT[i]] = any_hit(next_status, act_mask[i]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_status         <= '0;
			action_active_status <= '0;
		end else if (eval_tick) begin
			fault_status         <= next_status;
			action_active_status <= next_active;
		end
	end

	// action outputs driven from the active register; task1_op and task2_op from the task select registers
	assign amp_enable  = ~action_active_status[ACT_DISABLE];
	assign srq_out     = action_active_status[ACT_SRQ];
	assign srq_code    = srq_out ? SRQ_CODE_EXC : 8'h00;
	assign aux_out     = action_active_status[ACT_AUX];
	assign feed_hold   = action_active_status[ACT_FREEZE];
	assign task1_exc   = action_active_status[ACT_TASK1];
	assign task1_op    = first_task_exception_select;
	assign task2_exc   = action_active_status[ACT_TASK2];
	assign task2_op    = second_task_exception_select;
	assign pos_inhibit = action_active_status[ACT_POS];
	assign neg_inhibit = action_active_status[ACT_NEG];

	// read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (rd) begin
			if (addr == ADDR_INVERT) begin
				rdata <= DW'(polarity_invert_mask);
			end else if (addr == ADDR_LATCH_SL) begin
				rdata <= DW'(latch_select_mask);
			end else if (addr == ADDR_STATUS) begin
				rdata <= DW'(fault_status);
			end else if (addr >= ADDR_ACT_MASK && addr < ADDR_ACTIVE) begin
				rdata <= DW'(act_mask[3'(addr - ADDR_ACT_MASK)]);
			end else if (addr == ADDR_ACTIVE) begin
				rdata <= DW'(action_active_status);
			end else if (addr == ADDR_TASK_SEL) begin
				rdata <= {20'h00000, second_task_exception_select, 4'h0,
					first_task_exception_select};
			end else if (addr == ADDR_INTERVAL) begin
				rdata <= DW'(exception_update_interval);
			end else if (addr == ADDR_SRQ_CODE) begin
				rdata <= DW'(srq_code);
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end

	// assertions
	AST_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick |=> ((fault_status & ~$past(latch_select_mask))
			== (($past(fault_in) ^ $past(polarity_invert_mask)) & STATUS_VALID
			& ~$past(latch_select_mask))))
		else $error("unlatched status bit does not match inverted input");
	AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick |=> ((($past(fault_status) & $past(latch_select_mask)
			& ~$past(clear_pend)) & ~fault_status) == '0))
		else $error("latched status bit dropped without clear");
	AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
		(fault_status & ~STATUS_VALID) == '0)
		else $error("reserved status bit set");
	AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[0]) |=> !amp_enable)
		else $error("amplifier not disabled on masked fault");
	AST_SRQ_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		srq_out |-> srq_code == SRQ_CODE_EXC)
		else $error("service request code wrong");
	AST_UNUSED_BIT: assert property (@(posedge clk) disable iff (!rst_n)
		!action_active_status[1])
		else $error("unused active bit set");
	AST_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(eval_tick) |-> $stable(action_active_status))
		else $error("active register changed outside evaluation");
	AST_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[6]) |=> pos_inhibit)
		else $error("positive inhibit not raised");
	AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
		tick_cnt <= MAX_TICKS)
		else $error("evaluation interval exceeded");
	AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_LATCH_CL && !eval_tick |=> (clear_pend & $past(wdata[STW-1:0]))
			== $past(wdata[STW-1:0]))
		else $error("latch clear not recorded");

	COV_DISABLE: cover property (@(posedge clk) disable iff (!rst_n) $fell(amp_enable));
	COV_SRQ:     cover property (@(posedge clk) disable iff (!rst_n) $rose(srq_out));
	COV_LATCH:   cover property (@(posedge clk) disable iff (!rst_n)
		eval_tick && |(fault_status & latch_select_mask & ~fault_in));
	COV_CLEAR:   cover property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_LATCH_CL && wdata != '0);
	COV_HOLD:    cover property (@(posedge clk) disable iff (!rst_n)
		eval_tick ##1 feed_hold);

	// each action follows its mask at every evaluation, both ways

	AST_DISABLE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[0]) |=> amp_enable)
		else $error("amplifier disabled without masked fault");

	AST_SRQ_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[1]) |=> srq_out)
		else $error("service request not raised");

	AST_SRQ_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[1]) |=> !srq_out)
		else $error("service request raised without masked fault");

	AST_AUX_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[2]) |=> aux_out)
		else $error("auxiliary output not set");

	AST_AUX_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[2]) |=> !aux_out)
		else $error("auxiliary output set without masked fault");

	AST_HOLD_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[3]) |=> feed_hold)
		else $error("feed hold not raised");

	AST_HOLD_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[3]) |=> !feed_hold)
		else $error("feed hold raised without masked fault");

	AST_TASK1_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[4]) |=> task1_exc)
		else $error("first task exception not raised");

	AST_TASK1_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[4]) |=> !task1_exc)
		else $error("first task exception without masked fault");

	AST_TASK2_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[5]) |=> task2_exc)
		else $error("second task exception not raised");

	AST_TASK2_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[5]) |=> !task2_exc)
		else $error("second task exception without masked fault");

	AST_POS_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[6]) |=> !pos_inhibit)
		else $error("positive inhibit without masked fault");

	AST_NEG_SET: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && any_hit(next_status, act_mask[7]) |=> neg_inhibit)
		else $error("negative inhibit not raised");

	AST_NEG_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !any_hit(next_status, act_mask[7]) |=> !neg_inhibit)
		else $error("negative inhibit without masked fault");

	AST_TASK_OP: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_TASK_SEL |=> task1_op == $past(wdata[3:0])
			&& task2_op == $past(wdata[11:8]))
		else $error("task exception operation not taken");

	AST_SRQ_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!srq_out |-> srq_code == 8'h00)
		else $error("service request code without request");

	// status processing

	AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick |=> ((($past(fault_in) ^ $past(polarity_invert_mask)) & STATUS_VALID)
			& ~fault_status) == '0)
		else $error("true inverted source missing from status");

	AST_CLEAR_APPLY: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick |=> (fault_status & $past(clear_pend)
			& ~($past(fault_in) ^ $past(polarity_invert_mask))) == '0)
		else $error("cleared latch kept without source");

	AST_CLEAR_DONE: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick && !(wr && addr == ADDR_LATCH_CL) |=> clear_pend == '0)
		else $error("pending clear survived evaluation");

	AST_POL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_INVERT |=>
			polarity_invert_mask == ($past(wdata[STW-1:0]) & STATUS_VALID))
		else $error("invert mask write lost");

	AST_LSEL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_LATCH_SL |=>
			latch_select_mask == ($past(wdata[STW-1:0]) & STATUS_VALID))
		else $error("latch select write lost");

	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_ACT_MASK |=>
			act_mask[0] == ($past(wdata[STW-1:0]) & STATUS_VALID))
		else $error("action mask write lost");

	AST_MASK_RSV: assert property (@(posedge clk) disable iff (!rst_n)
		((polarity_invert_mask | latch_select_mask | act_mask[0] | act_mask[1]
			| act_mask[2] | act_mask[3] | act_mask[4] | act_mask[5]
			| act_mask[6] | act_mask[7]) & ~STATUS_VALID) == '0)
		else $error("reserved mask bit set");

	// register port

	AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_STATUS |=> rdata == DW'($past(fault_status)))
		else $error("status read wrong");

	AST_ACTIVE_READ: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_ACTIVE |=> rdata == DW'($past(action_active_status)))
		else $error("active register read wrong");

	AST_CODE_READ: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_SRQ_CODE |=> rdata == DW'($past(srq_code)))
		else $error("service request code read wrong");

	AST_READ_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!rd |=> rdata == '0)
		else $error("read data outside read cycle");

	// evaluation timing

	AST_EVAL_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		eval_tick |=> !eval_tick)
		else $error("evaluation pulse longer than one cycle");

	AST_TICK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!base_tick |=> $stable(tick_cnt))
		else $error("interval counter moved without base tick");

	AST_CYC_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		cyc_cnt < 16'(TICK_CYCLES))
		else $error("base divider out of range");

	AST_CLAMP: assert property (@(posedge clk) disable iff (!rst_n)
		interval_eff != 8'h00 && interval_eff <= MAX_TICKS)
		else $error("effective interval out of range");

endmodule : fmx_unit

/* File: fmx_src.sv */
// far-side model: fault sources and amplifier power stage
`timescale 1ns/1ps
module fmx_src (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [23:0] pattern,
	input  wire logic        amp_enable,
	output logic      [23:0] fault_in,
	output logic             amp_powered
);
	// sources settle one cycle after the bench asks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fault_in <= 24'h000000;
		else
			fault_in <= pattern;
	end
	// power stage follows its enable one cycle late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			amp_powered <= 1'b0;
		else
			amp_powered <= amp_enable;
	end
endmodule : fmx_src

/* File: tb.sv */
// testbench: register port, status processing and action masks
`timescale 1ns/1ps
module tb
	import fmx_pkg::*;
;
	localparam int ABIT [8] = '{0, 2, 3, 4, 5, 6, 7, 8};
	logic           clk;
	logic           rst_n;
	logic [STW-1:0] pattern;
	logic [STW-1:0] fault_in;
	logic [AW-1:0]  addr;
	logic [DW-1:0]  wdata;
	logic           wr;
	logic           rd;
	logic [DW-1:0]  rdata;
	logic [DW-1:0]  rv;
	logic [7:0]     srq_code;
	logic [3:0]     task1_op;
	logic [3:0]     task2_op;
	logic           amp_enable, amp_powered, srq_out, aux_out, feed_hold;
	logic           task1_exc, task2_exc, pos_inhibit, neg_inhibit, eval_tick;
	int             miscompares;
	int             compares;
	int             cyc;

	fmx_src src (.clk(clk), .rst_n(rst_n), .pattern(pattern), .amp_enable(amp_enable),
		.fault_in(fault_in), .amp_powered(amp_powered));
	fmx_unit #(.TICK_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n), .fault_in(fault_in),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.amp_enable(amp_enable), .srq_out(srq_out), .srq_code(srq_code), .aux_out(aux_out),
		.feed_hold(feed_hold), .task1_exc(task1_exc), .task1_op(task1_op),
		.task2_exc(task2_exc), .task2_op(task2_op), .pos_inhibit(pos_inhibit),
		.neg_inhibit(neg_inhibit), .eval_tick(eval_tick));

	task automatic conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	task automatic rreg(input logic [AW-1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : rreg
	// returns at the taking edge plus 1 ns; cyc is the spacing
	task automatic tick;
		int i;
		i = 1;
		@(posedge clk);
		while (eval_tick !== 1'b1) begin
			if (i == 1000) begin
				miscompares++;
				conclude;
			end
			@(posedge clk);
			i++;
		end
		cyc = i;
		#1;
	endtask : tick
	task automatic apply(input logic [STW-1:0] v);
		@(posedge clk);
		pattern <= v;
		tick;
		tick;
	endtask : apply

	task automatic t_reset;
		chk(32'(amp_enable), 32'h1);
		chk(32'({srq_out, aux_out, feed_hold, task1_exc, task2_exc, pos_inhibit}), 32'h0);
		rreg(ADDR_INTERVAL);
		chk(rv, 32'(INTERVAL_RST));
		@(posedge clk);
		#1 chk(rdata, 32'h0);
		tick;
		tick;
		chk(32'(cyc), 32'h200);
		wreg(ADDR_STATUS, 32'hffffffff);
		rreg(ADDR_STATUS);
		chk(rv, 32'h0);
		rreg(5'h1f);
		chk(rv, 32'h0);
	endtask : t_reset
	task automatic t_invert;
		wreg(ADDR_INTERVAL, 32'h2);
		wreg(ADDR_INVERT, 32'hffffff);
		apply(24'h000000);
		chk(32'(cyc), 32'h8);
		rreg(ADDR_STATUS);
		chk(rv, 32'h3ffbff);
		wreg(ADDR_INVERT, 32'h5);
		apply(24'h000104);
		rreg(ADDR_STATUS);
		chk(rv, 32'h000101);
	endtask : t_invert
	task automatic t_latch;
		wreg(ADDR_INVERT, 32'h80);
		wreg(ADDR_LATCH_SL, 32'hc0);
		apply(24'h000340);
		rreg(ADDR_STATUS);
		chk(rv, 32'h3c0);
		apply(24'h000080);
		rreg(ADDR_STATUS);
		chk(rv, 32'h0c0);
		wreg(ADDR_LATCH_CL, 32'h40);
		apply(24'h000080);
		rreg(ADDR_STATUS);
		chk(rv, 32'h080);
		wreg(ADDR_INVERT, 32'h0);
		wreg(ADDR_LATCH_SL, 32'h0);
		wreg(ADDR_LATCH_CL, 32'hffffff);
	endtask : t_latch
	task automatic t_actions;
		logic [8:0] act;
		wreg(ADDR_TASK_SEL, 32'h503);
		chk(32'({task2_op, task1_op}), 32'h53);
		for (int k = 0; k < 8; k++) begin
			wreg(ADDR_ACT_MASK + 5'(k), 32'h1 << (k + 12));
			apply(24'h1 << (k + 12));
			act = 9'h1 << ABIT[k];
			rreg(ADDR_ACTIVE);
			chk(rv, 32'(act));
			chk(32'({neg_inhibit, pos_inhibit, task2_exc, task1_exc, feed_hold, aux_out,
				srq_out, 1'b0, !amp_enable}), 32'(act));
			chk(32'(srq_code), k == 1 ? 32'h33 : 32'h0);
			if (k == 0)
				chk(32'(amp_powered), 32'h0);
			wreg(ADDR_ACT_MASK + 5'(k), 32'h0);
		end
		wreg(ADDR_ACT_MASK, 32'h400);
		apply(24'h000400);
		rreg(ADDR_ACTIVE);
		chk(rv, 32'h0);
	endtask : t_actions

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		pattern = '0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_invert;
		t_latch;
		t_actions;
		conclude;
	end
endmodule : tb
